// file: src/spf_config.sv
// Purpose: setting words, framing decode, transmit delay and receive end detect
// Assumes: inputs synchronous to mclk; rx_byte_vld one cycle per received byte
// Notes:   settings are decoded every cycle, so writes reach the decoded outputs one cycle after the word loads
//          an illegal port, custom baud or format code, or node number raises cfg_err; a bad port falls back to 7E2 9600, bad codes to 1.2k 7E1
//
// Behaviour
// R1: field zero gives standard 7E2 9600 framing
// R2: field one takes custom baud and format
// R3: baud codes 0..4 give 1.2k to 19.2k
// R4: frame format codes 00..11 select framing
// R5: 7/8 data, 1/2 stop, even/odd/none
// R6: transmit delay 0000..9999, default zero
// R7: delay is four BCD digits, 10 ms
// R8: node number two BCD digits, 00..31
// R9: start code enable gates start detection
// R10: start code byte in low bits
// R11: end mode: count, end code, CR LF
// R12: byte count 00 means 256 bytes
// R13: end code byte in high bits
// R14: settings take effect without load command
// R15: tool bus sticks until power or reconnect
// R16: mode field selects command protocol at zero
//
// Decided for this implementation: the address-and-strobe port.
module spf_config (
    input  wire logic                 mclk,
    input  wire logic                 srst,
    input  wire logic [15:0]          reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [15:0]               reg_rdata,
    input  wire logic                 cable_reconnect,
    input  wire logic                 tool_bus_seen,
    input  wire logic                 tx_req,
    output logic                      tx_go,
    input  wire logic                 rx_byte_vld,
    input  wire logic [7:0]           rx_byte,
    output logic                      rx_msg_end,
    output logic                      rx_start_ok,
    output spf_pkg::spf_frame_t       frame_cfg,
    output spf_pkg::spf_rx_cfg_t      rx_cfg,
    output logic [4:0]                node_num,
    output logic                      cfg_err
);

    // setting words as written by software; port select keeps bits 15:12 and 3:0 only
    logic [15:0] port_select_word_r;
    logic [15:0] serial_params_word_r;
    logic [15:0] transmit_delay_word_r;
    logic [15:0] node_and_code_enable_word_r;
    logic [15:0] start_end_code_word_r;
    logic        tool_bus_lock_r;
    logic [13:0] delay_units_r;
    logic [19:0] unit_cnt_r;
    logic        delay_busy_r;
    logic [8:0]  rx_cnt_r;
    logic        rx_prev_cr_r;
    logic        rx_in_msg_r;

    function automatic logic bcd_ok(input logic [7:0] v);
        bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9);
    endfunction : bcd_ok

    function automatic logic [7:0] bcd2bin(input logic [7:0] v);
        bcd2bin = 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]});
    endfunction : bcd2bin

    // register writes; settings drive decode directly
    always_ff @(posedge mclk) begin
        if (srst) begin
            port_select_word_r          <= spf_pkg::RST_WORD;
            serial_params_word_r        <= spf_pkg::RST_WORD;
            transmit_delay_word_r       <= spf_pkg::RST_WORD;
            node_and_code_enable_word_r <= spf_pkg::RST_WORD;
            start_end_code_word_r       <= spf_pkg::RST_WORD;
        end else if (reg_wr) begin // R14
            unique case (reg_addr)
                spf_pkg::ADDR_PORT_SELECT:
                    port_select_word_r <= reg_wdata & spf_pkg::PORT_SELECT_MASK;
                spf_pkg::ADDR_SERIAL_PARAM: serial_params_word_r        <= reg_wdata;
                spf_pkg::ADDR_TX_DELAY:     transmit_delay_word_r       <= reg_wdata;
                spf_pkg::ADDR_NODE_CODE_EN: node_and_code_enable_word_r <= reg_wdata;
                spf_pkg::ADDR_START_END:    start_end_code_word_r       <= reg_wdata;
                // unmapped and status writes are dropped
                default: ;
            endcase
        end
    end

    // tool bus lock, cleared only by reset or cable reconnect
    // a reconnect in the cycle that sees tool bus traffic leaves it set
    always_ff @(posedge mclk) begin
        if (srst) begin
            tool_bus_lock_r <= 1'b0;
        end else if (tool_bus_seen) begin
            tool_bus_lock_r <= 1'b1; // R15
        end else if (cable_reconnect) begin
            tool_bus_lock_r <= 1'b0; // R15
        end
    end

    // status word: delay busy, tool-bus lock, setting error
    logic [15:0] status_word;
    assign status_word = {13'h0000, delay_busy_r, tool_bus_lock_r, cfg_err};

    // read port
    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= spf_pkg::RST_WORD;
        end else if (reg_rd) begin
            unique case (reg_addr)
                spf_pkg::ADDR_PORT_SELECT:  reg_rdata <= port_select_word_r;
                spf_pkg::ADDR_SERIAL_PARAM: reg_rdata <= serial_params_word_r;
                spf_pkg::ADDR_TX_DELAY:     reg_rdata <= transmit_delay_word_r;
                spf_pkg::ADDR_NODE_CODE_EN: reg_rdata <= node_and_code_enable_word_r;
                spf_pkg::ADDR_START_END:    reg_rdata <= start_end_code_word_r;
                spf_pkg::ADDR_STATUS:       reg_rdata <= status_word;
                default:                    reg_rdata <= spf_pkg::RST_WORD;
            endcase
        end else begin
            reg_rdata <= spf_pkg::RST_WORD;
        end
    end

    // framing decode
    spf_pkg::spf_frame_t  frame_nxt;
    spf_pkg::spf_rx_cfg_t rx_cfg_nxt;
    logic [7:0]           fmt;
    logic [7:0]           fsub;
    logic                 err_nxt;

    always_comb begin
        fmt        = serial_params_word_r[15:8];
        fsub       = (fmt >= spf_pkg::FRAME_HALF) ? 8'(fmt - spf_pkg::FRAME_HALF) : fmt;
        err_nxt    = 1'b0;
        frame_nxt  = '0;
        // nonzero mode or a held lock selects tool bus
        frame_nxt.tool_bus = tool_bus_lock_r ||
                             (port_select_word_r[15:12] != spf_pkg::MODE_COMMAND); // R16 R15
        if (port_select_word_r[3:0] == spf_pkg::PORT_CUSTOM) begin // R2
            frame_nxt.baud_sel = 3'(serial_params_word_r[2:0]); // R3
            frame_nxt.data8    = (fmt >= spf_pkg::FRAME_HALF); // R4 R5
            frame_nxt.stop2    = (fsub >= spf_pkg::FRAME_STOP2); // R5
            unique case (fsub)
                8'h00, 8'h03: frame_nxt.parity = spf_pkg::PAR_EVEN;
                8'h01, 8'h04: frame_nxt.parity = spf_pkg::PAR_ODD;
                default:      frame_nxt.parity = spf_pkg::PAR_NONE;
            endcase
            if (serial_params_word_r[7:0] > spf_pkg::BAUD_MAX_CODE ||
                fmt > spf_pkg::FRAME_MAX_CODE) begin
                // illegal codes fall back to 1.2k 7E1
                err_nxt            = 1'b1;
                frame_nxt.baud_sel = '0;
                frame_nxt.data8    = 1'b0;
                frame_nxt.stop2    = 1'b0;
                frame_nxt.parity   = spf_pkg::PAR_EVEN;
            end
        end else begin
            frame_nxt.baud_sel = spf_pkg::BAUD_STD_SEL; // R1
            frame_nxt.data8    = 1'b0;
            frame_nxt.stop2    = 1'b1;
            frame_nxt.parity   = spf_pkg::PAR_EVEN;
            err_nxt            = (port_select_word_r[3:0] != spf_pkg::PORT_STANDARD);
        end
        if (!bcd_ok(node_and_code_enable_word_r[7:0]) ||
            node_and_code_enable_word_r[7:0] > spf_pkg::NODE_MAX) begin
            err_nxt = 1'b1;
        end
        rx_cfg_nxt            = '0;
        rx_cfg_nxt.start_en   = (node_and_code_enable_word_r[11:8] == spf_pkg::CODE_EN_ON); // R9
        rx_cfg_nxt.start_code = start_end_code_word_r[7:0]; // R10
        rx_cfg_nxt.end_code   = start_end_code_word_r[15:8]; // R13
        // byte count 00 stands for a full 256
        rx_cfg_nxt.byte_count = (start_end_code_word_r[15:8] == 8'h00) ?
                                spf_pkg::COUNT_FULL : {1'b0, start_end_code_word_r[15:8]}; // R12
        unique case (node_and_code_enable_word_r[15:12]) // R11
            spf_pkg::END_BY_CODE: rx_cfg_nxt.end_mode = spf_pkg::END_CODE;
            spf_pkg::END_BY_CRLF: rx_cfg_nxt.end_mode = spf_pkg::END_CRLF;
            default:              rx_cfg_nxt.end_mode = spf_pkg::END_COUNT;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            frame_cfg <= '0;
            rx_cfg    <= '0;
            node_num  <= '0;
            cfg_err   <= 1'b0;
        end else begin
            frame_cfg <= frame_nxt;
            rx_cfg    <= rx_cfg_nxt;
            node_num  <= 5'(bcd2bin(node_and_code_enable_word_r[7:0])); // R8
            cfg_err   <= err_nxt;
        end
    end

    // weight of a BCD digit of the delay word, units digit first
    function automatic logic [13:0] digit_weight(input int unsigned pos);
        digit_weight = 14'h0001;
        for (int unsigned k = 0; k < pos; k++) begin
            digit_weight = 14'(digit_weight * 14'd10);
        end
    endfunction : digit_weight

    // transmit delay: BCD digits summed into 10 ms units
    logic [13:0] delay_part [5];
    logic [13:0] delay_bin;

    assign delay_part[0] = 14'h0000;
    for (genvar d = 0; d < 4; d++) begin : g_delay_digit
        assign delay_part[d+1] = 14'(delay_part[d] +
            {10'h000, transmit_delay_word_r[4*d +: 4]} * digit_weight(d)); // R7
    end
    assign delay_bin = delay_part[4];

    always_ff @(posedge mclk) begin
        if (srst) begin
            delay_busy_r  <= 1'b0;
            delay_units_r <= '0;
            unit_cnt_r    <= '0;
            tx_go         <= 1'b0;
        end else begin
            tx_go <= 1'b0;
            // requests during a running delay are ignored
            if (!delay_busy_r) begin
                if (tx_req) begin
                    if (delay_bin == 14'h0000) begin
                        tx_go <= 1'b1; // R6
                    end else begin
                        delay_busy_r  <= 1'b1;
                        delay_units_r <= delay_bin;
                        unit_cnt_r    <= spf_pkg::CYC_PER_UNIT_W - 20'h00001;
                    end
                end
            // count down one 10 ms unit at a time, then pulse once
            end else if (unit_cnt_r != 20'h00000) begin
                unit_cnt_r <= unit_cnt_r - 20'h00001;
            end else if (delay_units_r == 14'h0001) begin
                delay_busy_r <= 1'b0;
                tx_go        <= 1'b1; // R6
            end else begin
                delay_units_r <= delay_units_r - 14'h0001;
                unit_cnt_r    <= spf_pkg::CYC_PER_UNIT_W - 20'h00001;
            end
        end
    end

    // end conditions for a byte arriving inside a message
    logic end_by_count;
    logic end_by_code;
    logic end_by_crlf;

    always_comb begin
        end_by_count = (rx_cfg.end_mode == spf_pkg::END_COUNT) &&
                       (9'(rx_cnt_r + 9'h001) == rx_cfg.byte_count); // R12
        end_by_code  = (rx_cfg.end_mode == spf_pkg::END_CODE) &&
                       (rx_byte == rx_cfg.end_code); // R13
        end_by_crlf  = (rx_cfg.end_mode == spf_pkg::END_CRLF) && rx_prev_cr_r &&
                       (rx_byte == spf_pkg::CHAR_LF); // R11
    end

    // receive framing: start code gate and end detection
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_cnt_r     <= '0;
            rx_prev_cr_r <= 1'b0;
            rx_in_msg_r  <= 1'b0;
            rx_msg_end   <= 1'b0;
            rx_start_ok  <= 1'b0;
        end else begin
            rx_msg_end  <= 1'b0;
            rx_start_ok <= 1'b0;
            if (rx_byte_vld) begin
                if (!rx_in_msg_r) begin
                    if (!rx_cfg.start_en || rx_byte == rx_cfg.start_code) begin // R9
                        rx_in_msg_r  <= 1'b1;
                        rx_start_ok  <= 1'b1;
                        rx_cnt_r     <= 9'h001;
                        rx_prev_cr_r <= (rx_byte == spf_pkg::CHAR_CR);
                        // the first byte may end a message; a start code does so only in count mode with count 1
                        if (rx_cfg.end_mode == spf_pkg::END_COUNT &&
                            rx_cfg.byte_count == 9'h001) begin
                            rx_in_msg_r <= 1'b0;
                            rx_msg_end  <= 1'b1;
                        end else if (rx_cfg.end_mode == spf_pkg::END_CODE &&
                                     rx_byte == rx_cfg.end_code && !rx_cfg.start_en) begin
                            rx_in_msg_r <= 1'b0;
                            rx_msg_end  <= 1'b1;
                        end
                    end
                end else begin
                    rx_cnt_r     <= 9'(rx_cnt_r + 9'h001);
                    rx_prev_cr_r <= (rx_byte == spf_pkg::CHAR_CR);
                    if (end_by_count || end_by_code || end_by_crlf) begin // R11 R12 R13
                        rx_in_msg_r <= 1'b0;
                        rx_msg_end  <= 1'b1;
                    end
                end
            end
        end
    end

endmodule : spf_config

// file: src/spf_pkg.sv
// Purpose: shared constants and types for the serial port framing config block
// Assumes: 100 MHz mclk, 16-bit setting words on a plain register port
// Notes:   register offsets are word addresses as printed
package spf_pkg;

    localparam int unsigned      CLK_HZ          = 100_000_000;
    localparam int unsigned      DELAY_UNIT_MS   = 10;
    localparam int unsigned      CYC_PER_UNIT    = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam logic [19:0]      CYC_PER_UNIT_W  = 20'(CYC_PER_UNIT);

    localparam logic [15:0] ADDR_PORT_SELECT  = 16'h19fa;
    localparam logic [15:0] ADDR_SERIAL_PARAM = 16'h19fb;
    localparam logic [15:0] ADDR_TX_DELAY     = 16'h19fc;
    localparam logic [15:0] ADDR_NODE_CODE_EN = 16'h19fd;
    localparam logic [15:0] ADDR_START_END    = 16'h19fe;
    localparam logic [15:0] ADDR_STATUS       = 16'h19ff;

    localparam logic [15:0] RST_WORD          = 16'h0000;
    localparam logic [15:0] PORT_SELECT_MASK  = 16'hf00f;

    localparam logic [3:0]  PORT_STANDARD     = 4'h0;
    localparam logic [3:0]  PORT_CUSTOM       = 4'h1;
    localparam logic [3:0]  MODE_COMMAND      = 4'h0;
    localparam logic [3:0]  CODE_EN_ON        = 4'h1;
    localparam logic [3:0]  END_BY_COUNT      = 4'h0;
    localparam logic [3:0]  END_BY_CODE       = 4'h1;
    localparam logic [3:0]  END_BY_CRLF       = 4'h2;

    localparam logic [7:0]  BAUD_MAX_CODE     = 8'h04;
    localparam logic [2:0]  BAUD_STD_SEL      = 3'h3;
    localparam logic [7:0]  FRAME_MAX_CODE    = 8'h0b;
    localparam logic [7:0]  FRAME_HALF        = 8'h06;
    localparam logic [7:0]  FRAME_STOP2       = 8'h03;
    localparam logic [7:0]  NODE_MAX          = 8'h31;
    localparam logic [8:0]  COUNT_FULL        = 9'h100;
    localparam logic [7:0]  CHAR_CR           = 8'h0d;
    localparam logic [7:0]  CHAR_LF           = 8'h0a;

    typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE} spf_parity_t;
    typedef enum logic [1:0] {END_COUNT, END_CODE, END_CRLF} spf_end_t;

    typedef struct packed {
        logic [2:0]  baud_sel;     // 0..4 = 1.2k..19.2k
        logic        data8;
        logic        stop2;
        spf_parity_t parity;
        logic        tool_bus;
    } spf_frame_t;

    typedef struct packed {
        logic        start_en;
        logic [7:0]  start_code;
        spf_end_t    end_mode;
        logic [7:0]  end_code;
        logic [8:0]  byte_count;
    } spf_rx_cfg_t;

endpackage : spf_pkg

// file: testbench/spf_config_assertions.sv
// Purpose: port-level checks for spf_config
// Assumes: one mclk domain, srst synchronous active high
// Notes:   bound from the bench top file
module spf_config_assertions (
    input wire logic                 mclk,
    input wire logic                 srst,
    input wire logic [15:0]          reg_addr,
    input wire logic [15:0]          reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [15:0]          reg_rdata,
    input wire logic                 tool_bus_seen,
    input wire logic                 tx_go,
    input wire logic                 rx_byte_vld,
    input wire logic                 rx_msg_end,
    input wire logic                 rx_start_ok,
    input wire spf_pkg::spf_frame_t  frame_cfg,
    input wire logic [4:0]           node_num
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_word_read_back: assert property ((reg_wr && reg_addr == spf_pkg::ADDR_TX_DELAY ##1
        reg_rd && reg_addr == spf_pkg::ADDR_TX_DELAY) |=> reg_rdata == $past(reg_wdata, 2))
        else $error("delay word read back wrong");
    a_tx_go_single: assert property (tx_go |=> !tx_go)
        else $error("transmit go longer than one cycle");
    a_std_frame_sel: assert property ((reg_wr && reg_addr == spf_pkg::ADDR_PORT_SELECT
        && reg_wdata[3:0] == 4'h0) |-> ##[2:3] (frame_cfg.baud_sel == 3'h3 && !frame_cfg.data8
        && frame_cfg.stop2 && frame_cfg.parity == spf_pkg::PAR_EVEN))
        else $error("standard framing not applied");
    a_node_bcd_dec: assert property ((reg_wr && reg_addr == spf_pkg::ADDR_NODE_CODE_EN
        && reg_wdata[7:0] == 8'h25) |-> ##[2:3] node_num == 5'd25)
        else $error("node number not decoded from bcd");
    a_end_has_byte: assert property (rx_msg_end |-> $past(rx_byte_vld))
        else $error("message end without a received byte");
    a_start_has_byte: assert property (rx_start_ok |-> $past(rx_byte_vld))
        else $error("start accepted without a received byte");
    a_tool_lock_set: assert property (tool_bus_seen |-> ##[1:2] frame_cfg.tool_bus)
        else $error("tool bus lock not taken");
    c_msg_end: cover property (rx_msg_end);
    c_tx_go: cover property (tx_go);
    c_lock: cover property (tool_bus_seen ##2 frame_cfg.tool_bus);
endmodule : spf_config_assertions

// file: testbench/spf_host_model.sv
// Purpose: serial-side host that feeds received bytes to spf_config
// Assumes: one byte strobe per call, flags registered one cycle later
// Notes:   released byte lines show the inverse of the last value
module spf_host_model (
    input  wire logic       mclk,
    input  wire logic       rx_start_ok,
    input  wire logic       rx_msg_end,
    output logic            rx_byte_vld,
    output logic [7:0]      rx_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_byte_vld = 1'b0;
        rx_byte = 8'h00;
    end
    task automatic send(input logic [7:0] b, output logic s, output logic e);
        @(posedge mclk);
        rx_byte_vld <= 1'b1;
        rx_byte <= b;
        @(posedge mclk);
        rx_byte_vld <= 1'b0;
        rx_byte <= ~b;
        #1;
        s = rx_start_ok;
        e = rx_msg_end;
    endtask : send
endmodule : spf_host_model

// file: testbench/test_spf_config.sv
// Purpose: self-checking bench for spf_config
// Assumes: 100 MHz mclk, read data one cycle after the strobe
// Notes:   nonzero transmit delays exceed the run length, only zero is timed
module test_spf_config;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, tx_req = 1'b0;
    logic cable_reconnect = 1'b0, tool_bus_seen = 1'b0, tx_go, rx_byte_vld, rx_msg_end;
    logic rx_start_ok, cfg_err;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata, q;
    logic [7:0] rx_byte;
    logic [4:0] node_num;
    spf_pkg::spf_frame_t  frame_cfg;
    spf_pkg::spf_rx_cfg_t rx_cfg;
    int fail_count = 0, check_count = 0, cyc = 0;
    spf_config dut_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cable_reconnect(cable_reconnect), .tool_bus_seen(tool_bus_seen), .tx_req(tx_req),
        .tx_go(tx_go), .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte), .rx_msg_end(rx_msg_end),
        .rx_start_ok(rx_start_ok), .frame_cfg(frame_cfg), .rx_cfg(rx_cfg),
        .node_num(node_num), .cfg_err(cfg_err));
    spf_host_model host_u (.mclk(mclk), .rx_start_ok(rx_start_ok), .rx_msg_end(rx_msg_end),
        .rx_byte_vld(rx_byte_vld), .rx_byte(rx_byte));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : wr
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
        @(posedge mclk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0; reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        r = reg_rdata;
    endtask : wr_rd
    task automatic rx(input logic [7:0] b, input logic es, input logic ee);
        logic s, e;
        host_u.send(b, s, e);
        chk("rx_start_ok", 32'(s), 32'(es));
        chk("rx_msg_end", 32'(e), 32'(ee));
    endtask : rx
    task automatic t_defaults();
        chk("frame_cfg", 32'(frame_cfg), 32'h68);
        chk("rx_cfg", 32'(rx_cfg), 32'h100);
        chk("node_num", 32'(node_num), 32'h0);
        chk("cfg_err", 32'(cfg_err), 32'h0);
        wr_rd(16'h0000, 16'h1234, q);
        chk("unmapped", 32'(q), 32'h0);
    endtask : t_defaults
    task automatic t_frames();
        wr_rd(spf_pkg::ADDR_PORT_SELECT, 16'h0ff1, q);
        chk("reserved", 32'(q), 32'h1);
        for (int i = 0; i < 12; i++) begin
            wr(spf_pkg::ADDR_SERIAL_PARAM, {8'(i), 8'(i % 5)});
            chk("frame", 32'(frame_cfg), 32'({3'(i % 5), 1'(i >= 6), 1'(i % 6 >= 3),
                2'(i % 3), 1'b0}));
        end
        wr(spf_pkg::ADDR_SERIAL_PARAM, 16'h0005);
        chk("bad baud", 32'(cfg_err), 32'h1);
        wr(spf_pkg::ADDR_SERIAL_PARAM, 16'h0c00);
        chk("bad frame", 32'(cfg_err), 32'h1);
        chk("fallback", 32'(frame_cfg), 32'h00);
        wr(spf_pkg::ADDR_PORT_SELECT, 16'h0002);
        chk("bad port", 32'(cfg_err), 32'h1);
        chk("bad port frame", 32'(frame_cfg), 32'h68);
        wr(spf_pkg::ADDR_PORT_SELECT, 16'h0000);
        chk("standard", 32'(frame_cfg), 32'h68);
        chk("err clear", 32'(cfg_err), 32'h0);
    endtask : t_frames
    task automatic t_tx();
        wr_rd(spf_pkg::ADDR_TX_DELAY, 16'h9999, q);
        chk("delay word", 32'(q), 32'h9999);
        wr(spf_pkg::ADDR_TX_DELAY, 16'h0000);
        @(posedge mclk) tx_req <= 1'b1;
        @(posedge mclk) tx_req <= 1'b0;
        #1 chk("tx_go", 32'(tx_go), 32'h1);
        @(posedge mclk) #1 chk("tx_go end", 32'(tx_go), 32'h0);
    endtask : t_tx
    task automatic t_node();
        wr(spf_pkg::ADDR_NODE_CODE_EN, 16'h0025);
        chk("node 25", 32'(node_num), 32'd25);
        wr(spf_pkg::ADDR_NODE_CODE_EN, 16'h0032);
        chk("node 32", 32'(cfg_err), 32'h1);
        wr(spf_pkg::ADDR_NODE_CODE_EN, 16'h0000);
    endtask : t_node
    task automatic t_rx();
        wr(spf_pkg::ADDR_START_END, 16'h0200);
        rx(8'h11, 1'b1, 1'b0);
        rx(8'h22, 1'b0, 1'b1);
        wr(spf_pkg::ADDR_START_END, 16'h0000);
        for (int i = 0; i < 256; i++) rx(8'(i), 1'(i == 0), 1'(i == 255));
        wr(spf_pkg::ADDR_NODE_CODE_EN, 16'h1100);
        wr(spf_pkg::ADDR_START_END, 16'h0302);
        rx(8'h41, 1'b0, 1'b0);
        rx(8'h02, 1'b1, 1'b0);
        rx(8'h41, 1'b0, 1'b0);
        rx(8'h03, 1'b0, 1'b1);
        wr(spf_pkg::ADDR_NODE_CODE_EN, 16'h2000);
        rx(8'h0d, 1'b1, 1'b0);
        rx(8'h0a, 1'b0, 1'b1);
    endtask : t_rx
    task automatic t_lock();
        wr(spf_pkg::ADDR_PORT_SELECT, 16'h1000);
        chk("mode 1", 32'(frame_cfg.tool_bus), 32'h1);
        wr(spf_pkg::ADDR_PORT_SELECT, 16'h0000);
        chk("mode 0", 32'(frame_cfg.tool_bus), 32'h0);
        @(posedge mclk) tool_bus_seen <= 1'b1;
        @(posedge mclk) tool_bus_seen <= 1'b0;
        wr(spf_pkg::ADDR_PORT_SELECT, 16'h0000);
        chk("locked", 32'(frame_cfg.tool_bus), 32'h1);
        @(posedge mclk) cable_reconnect <= 1'b1;
        @(posedge mclk) cable_reconnect <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("unlocked", 32'(frame_cfg.tool_bus), 32'h0);
    endtask : t_lock
    task automatic t_status();
        @(posedge mclk) begin
            tool_bus_seen   <= 1'b1;
            cable_reconnect <= 1'b1;
        end
        @(posedge mclk) begin
            tool_bus_seen   <= 1'b0;
            cable_reconnect <= 1'b0;
        end
        wr(spf_pkg::ADDR_TX_DELAY, 16'h0001);
        @(posedge mclk) tx_req <= 1'b1;
        @(posedge mclk) tx_req <= 1'b0;
        wr_rd(spf_pkg::ADDR_STATUS, 16'h0000, q);
        chk("status busy lock", 32'(q), 32'h6);
        chk("tx_go delayed", 32'(tx_go), 32'h0);
        @(posedge mclk) srst <= 1'b1;
        @(posedge mclk) srst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk("reset frame", 32'(frame_cfg), 32'h68);
        wr_rd(spf_pkg::ADDR_STATUS, 16'h0000, q);
        chk("reset status", 32'(q), 32'h0);
    endtask : t_status
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        t_defaults();
        t_frames();
        t_tx();
        t_node();
        t_rx();
        t_lock();
        t_status();
        conclude();
    end
endmodule : test_spf_config
bind spf_config spf_config_assertions chk_u (.mclk(mclk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tool_bus_seen(tool_bus_seen), .tx_go(tx_go), .rx_byte_vld(rx_byte_vld),
    .rx_msg_end(rx_msg_end), .rx_start_ok(rx_start_ok), .frame_cfg(frame_cfg),
    .node_num(node_num));
